// File: bsf_pkg.sv
// Package for the battery status flag logic: command codes, flag bit
// positions, thresholds, error codes and the structs that carry them.
// Assumes the measurement front end delivers its values in the units named here.
package bsf_pkg;

  // Command codes of the serial link.
  localparam logic [7:0] CMD_ERROR_MARGIN = 8'h0c;
  localparam logic [7:0] CMD_STATUS_FLAGS = 8'h2f;
  localparam logic [7:0] CMD_FINAL_EMPTY  = 8'h3f;
  localparam logic [7:0] CMD_SOFT_RESET   = 8'h44;

  // Software reset sequence values (8009 decimal, and the one excluded margin value).
  localparam logic [15:0] RESET_MAGIC    = 16'h1f49;
  localparam logic [15:0] MARGIN_NO_ARM  = 16'h0002;
  localparam logic [15:0] MARGIN_RESET   = 16'h0000;

  // Error codes reported in the status word.
  localparam logic [15:0] ERR_OK          = 16'h0000;
  localparam logic [15:0] ERR_UNSUPPORTED = 16'h0003;
  localparam logic [15:0] ERR_DENIED      = 16'h0004;

  // Bit positions inside the 16-bit combined flag word.
  localparam int unsigned BIT_DISPLAY    = 15;
  localparam int unsigned BIT_CELL       = 13;
  localparam int unsigned BIT_FULL_LOAD  = 12;
  localparam int unsigned BIT_PACK_HIGH  = 10;
  localparam int unsigned BIT_COLD       = 9;
  localparam int unsigned BIT_CURR_HIGH  = 8;
  localparam int unsigned BIT_VALID_CHG  = 5;
  localparam int unsigned BIT_WR_LOCK    = 4;
  localparam int unsigned BIT_VALID_DIS  = 3;
  localparam int unsigned BIT_HIGH_DRAIN = 2;
  localparam int unsigned BIT_EMPTY_1ST  = 1;
  localparam int unsigned BIT_EMPTY_FIN  = 0;
  localparam logic [15:0] FLAGS_RESET    = 16'h0000;

  // Pack voltage thresholds as ratios over 20 (1.05 and 0.95).
  localparam logic [20:0] PV_SCALE     = 21'h0_0014;
  localparam logic [20:0] PV_SET_RATIO = 21'h0_0015;
  localparam logic [20:0] PV_CLR_RATIO = 21'h0_0013;
  // Temperature in tenths of a degree Celsius, signed.
  localparam logic signed [15:0] COLD_SET_DC = 16'sh0000;
  localparam logic signed [15:0] COLD_CLR_DC = 16'sh0032;
  // Currents in mA, charges in mAh.
  localparam logic [15:0] CURR_SMALL_MA  = 16'h0400;
  localparam logic [15:0] CURR_MARGIN_MA = 16'h0100;
  localparam logic [15:0] CURR_CLR_MA    = 16'h0100;
  localparam logic [15:0] DRAIN_MA       = 16'h1806;
  localparam logic [15:0] VALID_CHG_MAH  = 16'h000a;
  localparam logic [15:0] SELF_DIS_MAH   = 16'h0100;

  typedef enum logic {SEQ_IDLE, SEQ_ARMED} bsf_seq_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [7:0]  code;
    logic [15:0] wdata;
  } bsf_cmd_type;

  typedef struct packed {
    logic        valid;
    logic        denied;
    logic [15:0] data;
  } bsf_rsp_type;

  typedef struct packed {
    logic        display_scale_select;
    logic        cell_type_select;
    logic        full_on_finish_select;
    logic        write_lock_flag;
    logic [15:0] final_empty_voltage;
  } bsf_cfg_type;

  typedef struct packed {
    logic [15:0]        pack_mv;
    logic [15:0]        charge_mv;
    logic signed [15:0] temp_dc;
    logic [15:0]        avg_ma;
    logic [15:0]        charge_ma;
    logic [15:0]        discharge_ma;
    logic [15:0]        sense_charge;
    logic [15:0]        sense_dis_mag;
    logic [15:0]        accum_mah;
    logic [15:0]        self_dis_mah;
    logic [15:0]        first_empty_mv;
    logic [15:0]        remaining_charge;
    logic [15:0]        learned_full_capacity;
    logic               charging;
    logic               discharging;
    logic               charge_finish;
  } bsf_meas_type;

endpackage

// File: bsf_flag_cell.sv
// One status flag with separate set and clear conditions.
// Assumes set and clear are already synchronous to the clock.
`timescale 1ns/1ps
module bsf_flag_cell (
  input  wire logic i_clock,
  input  wire logic i_nrst,
  input  wire logic i_reinit,
  input  wire logic i_set,
  input  wire logic i_clear,
  output logic      o_flag
);
  logic flag_r;
  logic flag_nxt;

  // Set wins over clear so that an event arriving with a clear is not lost.
  assign flag_nxt = i_reinit ? 1'b0 : (i_set | (flag_r & ~i_clear));
  assign o_flag   = flag_r;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end
endmodule

// File: bsf_status_flags.sv
// Top of the battery status flag logic: flag evaluation, command decode,
// write lock and software reset sequence.
// Assumes a link front end that hands over one decoded command word at a time
// and an EEPROM reader that presents configuration on i_cfg_load.
`timescale 1ns/1ps
// Contract
// - Command 0x2f reads the flag word, high byte over low byte, read-only.
// - High bit 7 picks absolute (0) or relative (1) display.
// - High bit 5 picks nickel (0) or lithium-ion (1) compensation.
// - High bit 4 set: valid charge finish loads remaining charge from full capacity.
// - Pack-high flag sets at 1.05x charge voltage, clears at 0.95x.
// - Cold flag sets below 0 C, clears only above 5 C.
// - Current-high flag sets when average current exceeds charge current by 25%.
// - Below 1024 mA charge current, that margin is 256 mA instead.
// - Current-high flag clears only when average current is below 256 mA.
// - Valid charge sets at sense threshold plus 10 mAh; clears on discharge or threshold.
// - Write lock at 1 rejects every write; at 0 writes to codes 0x0c and 0x44 are allowed.
// - Valid discharge sets on first discharge after remaining equals full capacity.
// - Valid discharge clears on partial charge, cold first-empty, or self-discharge over 256.
// - High-drain flag follows discharge current above 6.15 A.
// - First-empty flag sets below threshold without high drain; clears with valid charge.
// - Final-empty flag sets below threshold without high drain; clears with valid charge.
// - High bits 6 and 3 and low bits 7 and 6 are reserved zero.
// - That sequence reinitialises the block and requests an EEPROM reload.
// - Command 0x3f reads the final empty voltage, read-only.
// - A write to a read-only code is refused with error code 0x0004.
module bsf_status_flags (
  input  wire logic                  i_clock,
  input  wire logic                  i_nrst,
  input  wire bsf_pkg::bsf_cmd_type  i_cmd,
  input  wire bsf_pkg::bsf_meas_type i_meas,
  input  wire logic                  i_cfg_load,
  input  wire bsf_pkg::bsf_cfg_type  i_cfg,
  output bsf_pkg::bsf_rsp_type       o_rsp,
  output logic [15:0]                o_error_code,
  output logic [15:0]                o_flags,
  output logic                       o_display_relative,
  output logic                       o_cell_li_ion,
  output logic                       o_rm_load,
  output logic                       o_reload_request
);
  bsf_pkg::bsf_cfg_type  cfg_r;
  bsf_pkg::bsf_rsp_type  rsp_r;
  bsf_pkg::bsf_seq_type  seq_r;
  bsf_pkg::bsf_seq_type  seq_nxt;
  logic [15:0]           margin_r;
  logic [15:0]           error_r;
  logic [15:0]           error_nxt;
  logic [15:0]           flags_r;
  logic [15:0]           flag_word;
  logic                  full_seen_r;
  logic                  rm_load_r;
  logic                  reload_r;
  logic                  first_empty_d_r;

  // Flag cell outputs.
  logic pack_high;
  logic cold;
  logic curr_high;
  logic valid_chg;
  logic valid_dis;
  logic high_drain;
  logic empty_first;
  logic empty_final;

  // Threshold arithmetic, widened so that no product wraps.
  logic [20:0] pv_scaled;
  logic [20:0] cv_set;
  logic [20:0] cv_clr;
  logic [18:0] avg_x4;
  logic [18:0] chg_x5;
  logic [16:0] chg_plus;
  logic        pv_set;
  logic        pv_clr;
  logic        oc_set;
  logic        oc_clr;
  logic        vq_set;
  logic        vq_clr;
  logic        vdq_set;
  logic        vdq_clr;
  logic        e1_set;
  logic        e1_clr;
  logic        ef_set;
  logic        ef_clr;
  logic        e1_rise;

  // Command decode.
  logic is_rd;
  logic is_wr;
  logic hit_margin;
  logic hit_flags;
  logic hit_final;
  logic hit_reset;
  logic known;
  logic wr_ok;
  logic wr_ro;
  logic do_reset;
  logic reinit;

  assign pv_scaled = 21'(i_meas.pack_mv) * bsf_pkg::PV_SCALE;
  assign cv_set    = 21'(i_meas.charge_mv) * bsf_pkg::PV_SET_RATIO;
  assign cv_clr    = 21'(i_meas.charge_mv) * bsf_pkg::PV_CLR_RATIO;
  assign pv_set    = pv_scaled >= cv_set;
  assign pv_clr    = pv_scaled < cv_clr;

  assign avg_x4    = {1'b0, i_meas.avg_ma, 2'b00};
  assign chg_x5    = {1'b0, i_meas.charge_ma, 2'b00} + 19'(i_meas.charge_ma);
  assign chg_plus  = 17'(i_meas.charge_ma) + 17'(bsf_pkg::CURR_MARGIN_MA);
  // Small charge currents use a fixed margin because 25% would be too tight.
  assign oc_set    = (i_meas.charge_ma < bsf_pkg::CURR_SMALL_MA) ?
                     (17'(i_meas.avg_ma) > chg_plus) :
                     (avg_x4 > chg_x5);
  assign oc_clr    = i_meas.avg_ma < bsf_pkg::CURR_CLR_MA;

  assign vq_set    = (i_meas.sense_charge >= i_meas.sense_dis_mag) &&
                     (i_meas.accum_mah >= bsf_pkg::VALID_CHG_MAH);
  assign vq_clr    = i_meas.discharging ||
                     (i_meas.sense_charge <= i_meas.sense_dis_mag);

  assign vdq_set   = full_seen_r & i_meas.discharging;
  assign e1_rise   = empty_first & ~first_empty_d_r;
  assign vdq_clr   = (valid_dis & i_meas.charging) ||
                     (e1_rise && (i_meas.temp_dc < bsf_pkg::COLD_SET_DC)) ||
                     (i_meas.self_dis_mah > bsf_pkg::SELF_DIS_MAH);

  assign e1_set    = (i_meas.pack_mv < i_meas.first_empty_mv) & ~high_drain;
  assign e1_clr    = valid_chg & (i_meas.pack_mv > i_meas.first_empty_mv);
  assign ef_set    = (i_meas.pack_mv < cfg_r.final_empty_voltage) & ~high_drain;
  assign ef_clr    = valid_chg & (i_meas.pack_mv > cfg_r.final_empty_voltage);

  bsf_flag_cell u_pack_high (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (pv_set),
    .i_clear  (pv_clr),
    .o_flag   (pack_high)
  );
  bsf_flag_cell u_cold (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (i_meas.temp_dc < bsf_pkg::COLD_SET_DC),
    .i_clear  (i_meas.temp_dc > bsf_pkg::COLD_CLR_DC),
    .o_flag   (cold)
  );
  bsf_flag_cell u_curr_high (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (oc_set),
    .i_clear  (oc_clr),
    .o_flag   (curr_high)
  );
  bsf_flag_cell u_valid_chg (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (vq_set),
    .i_clear  (vq_clr),
    .o_flag   (valid_chg)
  );
  bsf_flag_cell u_valid_dis (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (vdq_set),
    .i_clear  (vdq_clr),
    .o_flag   (valid_dis)
  );
  bsf_flag_cell u_high_drain (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (i_meas.discharge_ma > bsf_pkg::DRAIN_MA),
    .i_clear  (i_meas.discharge_ma < bsf_pkg::DRAIN_MA),
    .o_flag   (high_drain)
  );
  bsf_flag_cell u_empty_first (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (e1_set),
    .i_clear  (e1_clr),
    .o_flag   (empty_first)
  );
  bsf_flag_cell u_empty_final (
    .i_clock  (i_clock),
    .i_nrst   (i_nrst),
    .i_reinit (reinit),
    .i_set    (ef_set),
    .i_clear  (ef_clr),
    .o_flag   (empty_final)
  );

  // Reserved positions stay zero because the word is built from zero.
  always_comb begin
    flag_word                           = bsf_pkg::FLAGS_RESET;
    flag_word[bsf_pkg::BIT_DISPLAY]     = cfg_r.display_scale_select;
    flag_word[bsf_pkg::BIT_CELL]        = cfg_r.cell_type_select;
    flag_word[bsf_pkg::BIT_FULL_LOAD]   = cfg_r.full_on_finish_select;
    flag_word[bsf_pkg::BIT_PACK_HIGH]   = pack_high;
    flag_word[bsf_pkg::BIT_COLD]        = cold;
    flag_word[bsf_pkg::BIT_CURR_HIGH]   = curr_high;
    flag_word[bsf_pkg::BIT_VALID_CHG]   = valid_chg;
    flag_word[bsf_pkg::BIT_WR_LOCK]     = cfg_r.write_lock_flag;
    flag_word[bsf_pkg::BIT_VALID_DIS]   = valid_dis;
    flag_word[bsf_pkg::BIT_HIGH_DRAIN]  = high_drain;
    flag_word[bsf_pkg::BIT_EMPTY_1ST]   = empty_first;
    flag_word[bsf_pkg::BIT_EMPTY_FIN]   = empty_final;
  end

  assign is_rd      = i_cmd.valid & ~i_cmd.write;
  assign is_wr      = i_cmd.valid & i_cmd.write;
  assign hit_margin = i_cmd.code == bsf_pkg::CMD_ERROR_MARGIN;
  assign hit_flags  = i_cmd.code == bsf_pkg::CMD_STATUS_FLAGS;
  assign hit_final  = i_cmd.code == bsf_pkg::CMD_FINAL_EMPTY;
  assign hit_reset  = i_cmd.code == bsf_pkg::CMD_SOFT_RESET;
  assign known      = hit_margin | hit_flags | hit_final | hit_reset;
  assign wr_ro      = is_wr & (hit_flags | hit_final);
  assign wr_ok      = is_wr & ~cfg_r.write_lock_flag & (hit_margin | hit_reset);
  assign do_reset   = wr_ok & hit_reset & (seq_r == bsf_pkg::SEQ_ARMED) &
                      (i_cmd.wdata == bsf_pkg::RESET_MAGIC);
  assign reinit     = reload_r;

  // Arming needs a margin write other than 2; any unlocked reset-code write disarms.
  always_comb begin
    seq_nxt = seq_r;
    if (wr_ok && hit_margin) begin
      seq_nxt = (i_cmd.wdata != bsf_pkg::MARGIN_NO_ARM) ?
                bsf_pkg::SEQ_ARMED : bsf_pkg::SEQ_IDLE;
    end else if (wr_ok && hit_reset) begin
      seq_nxt = bsf_pkg::SEQ_IDLE;
    end
  end

  // A read sets the error to OK for a known code and to unsupported otherwise.
  always_comb begin
    error_nxt = error_r;
    if (is_rd) begin
      error_nxt = known ? bsf_pkg::ERR_OK : bsf_pkg::ERR_UNSUPPORTED;
    end else if (wr_ro || (is_wr && cfg_r.write_lock_flag && known)) begin
      error_nxt = bsf_pkg::ERR_DENIED;
    end else if (is_wr && !known) begin
      error_nxt = bsf_pkg::ERR_UNSUPPORTED;
    end else if (is_wr) begin
      error_nxt = bsf_pkg::ERR_OK;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      rsp_r   <= '0;
      error_r <= bsf_pkg::ERR_OK;
      seq_r   <= bsf_pkg::SEQ_IDLE;
    end else begin
      rsp_r.valid  <= i_cmd.valid;
      rsp_r.denied <= wr_ro | (is_wr & cfg_r.write_lock_flag);
      rsp_r.data   <= !is_rd ? 16'h0000 :
                      hit_flags  ? flag_word :
                      hit_final  ? cfg_r.final_empty_voltage :
                      hit_margin ? margin_r : 16'h0000;
      error_r      <= reload_r ? bsf_pkg::ERR_OK : error_nxt;
      seq_r        <= reload_r ? bsf_pkg::SEQ_IDLE : seq_nxt;
    end
  end

  // Configuration comes only from the EEPROM reader; the reset sequence wipes it.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_r    <= '0;
      margin_r <= bsf_pkg::MARGIN_RESET;
    end else if (reload_r) begin
      cfg_r    <= '0;
      margin_r <= bsf_pkg::MARGIN_RESET;
    end else begin
      if (i_cfg_load) begin
        cfg_r <= i_cfg;
      end
      if (wr_ok && hit_margin) begin
        margin_r <= i_cmd.wdata;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      flags_r         <= bsf_pkg::FLAGS_RESET;
      full_seen_r     <= 1'b0;
      rm_load_r       <= 1'b0;
      reload_r        <= 1'b0;
      first_empty_d_r <= 1'b0;
    end else begin
      flags_r         <= flag_word;
      full_seen_r     <= ~reload_r & ~i_meas.discharging &
                         (full_seen_r |
                          (i_meas.remaining_charge == i_meas.learned_full_capacity));
      rm_load_r       <= i_meas.charge_finish & cfg_r.full_on_finish_select;
      reload_r        <= do_reset;
      first_empty_d_r <= empty_first;
    end
  end

  assign o_rsp              = rsp_r;
  assign o_error_code       = error_r;
  assign o_flags            = flags_r;
  assign o_display_relative = cfg_r.display_scale_select;
  assign o_cell_li_ion      = cfg_r.cell_type_select;
  assign o_rm_load          = rm_load_r;
  assign o_reload_request   = reload_r;

  property p_read_answer;
    @(posedge i_clock) disable iff (!i_nrst)
    is_rd |=> rsp_r.valid;
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("Read not answered.");

  property p_flag_snapshot;
    @(posedge i_clock) disable iff (!i_nrst)
    (is_rd && hit_flags) |=> (rsp_r.data == $past(flag_word));
  endproperty
  a_flag_snapshot: assert property (p_flag_snapshot) else $error("Bad flag word.");

  property p_ro_denied;
    @(posedge i_clock) disable iff (!i_nrst)
    wr_ro |=> (error_r == 16'h0004) && rsp_r.denied;
  endproperty
  a_ro_denied: assert property (p_ro_denied) else $error("Read-only write taken.");

  property p_lock_holds;
    @(posedge i_clock) disable iff (!i_nrst)
    (is_wr && cfg_r.write_lock_flag && !i_cfg_load) |=> $stable(margin_r) && !reload_r;
  endproperty
  a_lock_holds: assert property (p_lock_holds) else $error("Locked write taken.");

  property p_cold_set;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_meas.temp_dc < 16'sh0000 && !reload_r) |=> cold ##1 flags_r[9];
  endproperty
  a_cold_set: assert property (p_cold_set) else $error("Cold flag missed.");

  property p_drain;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_meas.discharge_ma > 16'h1806 && !reload_r) |=> high_drain;
  endproperty
  a_drain: assert property (p_drain) else $error("High drain missed.");

  property p_reset_seq;
    @(posedge i_clock) disable iff (!i_nrst)
    (is_wr && hit_reset && !cfg_r.write_lock_flag && seq_r == bsf_pkg::SEQ_ARMED &&
     i_cmd.wdata == 16'h1f49) |=> reload_r ##1 (cfg_r == '0) && (error_r == 16'h0000);
  endproperty
  a_reset_seq: assert property (p_reset_seq) else $error("Reset sequence ignored.");

  property p_empty_gate;
    @(posedge i_clock) disable iff (!i_nrst)
    $rose(empty_first) |-> $past(!high_drain);
  endproperty
  a_empty_gate: assert property (p_empty_gate) else $error("Empty set in drain.");

  property p_reserved;
    @(posedge i_clock) disable iff (!i_nrst)
    (o_flags & 16'h48c0) == 16'h0000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set.");

  property p_curr_clear;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_meas.avg_ma < 16'h0100 && !oc_set) |=> !curr_high;
  endproperty
  a_curr_clear: assert property (p_curr_clear) else $error("Current flag stuck.");

  c_reset_seq: cover property (@(posedge i_clock) disable iff (!i_nrst) reload_r);
  c_valid_dis: cover property (@(posedge i_clock) disable iff (!i_nrst) $rose(valid_dis));
  c_flag_read: cover property (@(posedge i_clock) disable iff (!i_nrst) is_rd && hit_flags);
endmodule

// File: bsf_eeprom_model.sv
// Model of the EEPROM reader that answers reload requests of the flag logic.
// Assumes the bench sets the image that the memory holds.
`timescale 1ns/1ps
module bsf_eeprom_model (
  input  wire logic                 i_clock,
  input  wire logic                 i_nrst,
  input  wire logic                 i_request,
  input  wire bsf_pkg::bsf_cfg_type i_image,
  output logic                      o_load,
  output bsf_pkg::bsf_cfg_type      o_cfg
);
  logic [2:0] dly_r;
  // A reload takes a few cycles, as a serial read would; outside the load
  // pulse the bus shows the inverse image so a stray capture is seen.
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      dly_r  <= 3'h0;
      o_load <= 1'b0;
      o_cfg  <= '0;
    end else begin
      dly_r  <= i_request ? 3'h4 : (dly_r != 3'h0 ? dly_r - 3'h1 : 3'h0);
      o_load <= (dly_r == 3'h1);
      o_cfg  <= (dly_r == 3'h1) ? i_image : ~i_image;
    end
  end
endmodule

// File: tb.sv
// Self-checking bench of the status flag logic with a flag model.
// Assumes the EEPROM reader model answers reload requests.
`timescale 1ns/1ps
module tb;
  logic                  i_clock, i_nrst, load_req, cfg_load, reload, rel, li, rm_load;
  bsf_pkg::bsf_cmd_type  cmd;
  bsf_pkg::bsf_meas_type m, v;
  bsf_pkg::bsf_cfg_type  image, cfg;
  bsf_pkg::bsf_rsp_type  rsp;
  logic [15:0]           err, flags, fl, cw, fev;
  int                    miscompares, total_checks;
  logic                  fs;

  bsf_status_flags bsf_status_flags_i (.i_clock(i_clock), .i_nrst(i_nrst), .i_cmd(cmd),
    .i_meas(m), .i_cfg_load(cfg_load), .i_cfg(cfg), .o_rsp(rsp), .o_error_code(err),
    .o_flags(flags), .o_display_relative(rel), .o_cell_li_ion(li), .o_rm_load(rm_load),
    .o_reload_request(reload));
  bsf_eeprom_model bsf_eeprom_model_i (.i_clock(i_clock), .i_nrst(i_nrst),
    .i_request(reload | load_req), .i_image(image), .o_load(cfg_load), .o_cfg(cfg));

  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic send(input logic wr, input logic [7:0] code, input logic [15:0] wd,
                      input logic [15:0] exp_d, input logic [15:0] exp_e, input logic dn);
    @(posedge i_clock);
    cmd <= '{1'b1, wr, code, wd};
    @(posedge i_clock);
    cmd.valid <= 1'b0;
    // The answer stands for one cycle only, so it is read just after it appears.
    #1;
    check("rsp_valid", 16'(rsp.valid), 16'h0001);
    check("rsp_data", rsp.data, exp_d);
    check("rsp_denied", 16'(rsp.denied), 16'(dn));
    check("error_code", err, exp_e);
  endtask

  task automatic waitload;
    for (int n = 0; n < 20 && cfg_load !== 1'b1; n++) begin
      @(posedge i_clock);
      #1;
    end
    if (cfg_load !== 1'b1) begin
      miscompares++;
      results();
    end
    repeat (2) @(posedge i_clock);
    #1;
    cw = {image.display_scale_select, 1'b0, image.cell_type_select,
          image.full_on_finish_select, 7'h00, image.write_lock_flag, 4'h0};
    fev = image.final_empty_voltage;
    check("display", 16'(rel), 16'(image.display_scale_select));
    check("cell", 16'(li), 16'(image.cell_type_select));
  endtask

  task automatic load(input logic lock);
    @(posedge i_clock);
    image <= '{1'($urandom), 1'($urandom), 1'b1, lock, 16'($urandom_range(5000, 3000))};
    load_req <= 1'b1;
    @(posedge i_clock);
    load_req <= 1'b0;
    waitload();
  endtask

  // The model settles each flag once; set wins where both conditions hold.
  task automatic apply;
    int p, c, a, g, t;
    @(posedge i_clock);
    m <= v;
    p = v.pack_mv * 20;
    c = v.charge_mv;
    a = v.avg_ma;
    g = v.charge_ma;
    t = $signed(v.temp_dc);
    if (p >= c * 21) fl[10] = 1'b1;
    else if (p < c * 19) fl[10] = 1'b0;
    if (t < 0) fl[9] = 1'b1;
    else if (t > 50) fl[9] = 1'b0;
    if (g < 1024 ? a > g + 256 : a * 4 > g * 5) fl[8] = 1'b1;
    else if (a < 256) fl[8] = 1'b0;
    if (v.sense_charge >= v.sense_dis_mag && v.accum_mah >= 10) fl[5] = 1'b1;
    else if (v.discharging || v.sense_charge <= v.sense_dis_mag) fl[5] = 1'b0;
    // At exactly the drain limit the flag keeps its state.
    if (v.discharge_ma > 16'h1806) fl[2] = 1'b1;
    else if (v.discharge_ma < 16'h1806) fl[2] = 1'b0;
    if (fs && v.discharging) fl[3] = 1'b1;
    else if ((fl[3] && v.charging) || v.self_dis_mah > 256) fl[3] = 1'b0;
    fs = !v.discharging && (fs || v.remaining_charge == v.learned_full_capacity);
    if (v.pack_mv < v.first_empty_mv && !fl[2]) fl[1] = 1'b1;
    else if (fl[5] && v.pack_mv > v.first_empty_mv) fl[1] = 1'b0;
    if (v.pack_mv < fev && !fl[2]) fl[0] = 1'b1;
    else if (fl[5] && v.pack_mv > fev) fl[0] = 1'b0;
    repeat (3) @(posedge i_clock);
    send(1'b0, 8'h2f, 16'h0000, cw | fl, 16'h0000, 1'b0);
    check("o_flags", flags, cw | fl);
  endtask

  initial begin
    repeat (50000) @(posedge i_clock);
    miscompares++;
    results();
  end

  initial begin
    i_nrst = 1'b0;
    load_req = 1'b0;
    cmd = '0;
    image = '0;
    v = '{pack_mv: 16'h10cc, charge_mv: 16'h1068, default: '0};
    // Settled measurements stand through reset, so no flag sets on an all-zero bus.
    m = v;
    fl = '0;
    fs = 1'b0;
    void'($urandom(32'h2d6a));
    repeat (12) @(posedge i_clock);
    i_nrst <= 1'b1;
    load(1'b1);
    apply();
    send(1'b1, 8'h0c, 16'h0005, 16'h0000, 16'h0004, 1'b1);
    send(1'b1, 8'h44, 16'h1f49, 16'h0000, 16'h0004, 1'b1);
    check("reload", 16'(reload), 16'h0000);
    load(1'b0);
    send(1'b1, 8'h0c, 16'h0002, 16'h0000, 16'h0000, 1'b0);
    send(1'b0, 8'h0c, 16'h0000, 16'h0002, 16'h0000, 1'b0);
    send(1'b1, 8'h44, 16'h1f49, 16'h0000, 16'h0000, 1'b0);
    check("reload", 16'(reload), 16'h0000);
    send(1'b0, 8'h55, 16'h0000, 16'h0000, 16'h0003, 1'b0);
    send(1'b0, 8'h3f, 16'h0000, fev, 16'h0000, 1'b0);
    send(1'b1, 8'h2f, 16'hffff, 16'h0000, 16'h0004, 1'b1);
    send(1'b1, 8'h3f, 16'hffff, 16'h0000, 16'h0004, 1'b1);
    v.pack_mv = 16'h113a;
    apply();
    v.pack_mv = 16'h0f3c;
    apply();
    v.temp_dc = 16'hffff;
    apply();
    v.temp_dc = 16'h001e;
    apply();
    v.temp_dc = 16'h0033;
    apply();
    v.charge_ma = 16'h07d0;
    v.avg_ma = 16'h09c5;
    apply();
    v.avg_ma = 16'h012c;
    apply();
    v.avg_ma = 16'h00ff;
    apply();
    v.charge_ma = 16'h01f4;
    v.avg_ma = 16'h02f4;
    apply();
    v.avg_ma = 16'h02f5;
    apply();
    v.avg_ma = 16'h0064;
    apply();
    v.discharge_ma = 16'h1807;
    apply();
    v.discharge_ma = 16'h1806;
    apply();
    v.discharge_ma = 16'h1805;
    v.first_empty_mv = 16'h1388;
    apply();
    v.sense_charge = 16'h0005;
    v.sense_dis_mag = 16'h0005;
    v.accum_mah = 16'h000a;
    apply();
    v.pack_mv = 16'h1450;
    apply();
    v.discharging = 1'b1;
    v.accum_mah = 16'h0000;
    apply();
    v.discharging = 1'b0;
    v.charging = 1'b1;
    apply();
    send(1'b1, 8'h0c, 16'h0005, 16'h0000, 16'h0000, 1'b0);
    send(1'b1, 8'h44, 16'h1f49, 16'h0000, 16'h0000, 1'b0);
    check("reload", 16'(reload), 16'h0001);
    fl = '0;
    cw = '0;
    waitload();
    apply();
    send(1'b0, 8'h0c, 16'h0000, 16'h0000, 16'h0000, 1'b0);
    @(posedge i_clock);
    m.charge_finish <= 1'b1;
    @(posedge i_clock);
    m.charge_finish <= 1'b0;
    #1;
    check("rm_load", 16'(rm_load), 16'h0001);
    results();
  end
endmodule
